// >>> hw/vrb_defs.svh
// Register indices, field positions, reset values and timing figures of the rail register bank
`ifndef VRB_DEFS_SVH
`define VRB_DEFS_SVH

`define VRB_IDX_VENDOR      8'h00
`define VRB_IDX_PART        8'h01
`define VRB_IDX_REVISION    8'h02
`define VRB_IDX_PROTOCOL    8'h05
`define VRB_IDX_CAPABILITY  8'h06
`define VRB_IDX_STAT_PRI    8'h10
`define VRB_IDX_STAT_SEC    8'h11
`define VRB_IDX_TEMP_ZONE   8'h12
`define VRB_IDX_IOUT        8'h15
`define VRB_IDX_VOUT        8'h16
`define VRB_IDX_TEMP        8'h17
`define VRB_IDX_POUT        8'h18
`define VRB_IDX_STAT_SNAP   8'h1C
`define VRB_IDX_CUR_LIMIT   8'h21
`define VRB_IDX_TEMP_LIMIT  8'h22
`define VRB_IDX_FAST_SLEW   8'h24
`define VRB_IDX_SLOW_SLEW   8'h25
`define VRB_IDX_BOOT        8'h26
`define VRB_IDX_SLOW_SEL    8'h2A
`define VRB_IDX_DEEP_LAT    8'h2B
`define VRB_IDX_LIGHT_LAT   8'h2C
`define VRB_IDX_EN_LAT      8'h2D
`define VRB_IDX_CEILING     8'h30
`define VRB_IDX_TARGET      8'h31
`define VRB_IDX_MULTI_RAIL  8'h34

`define VRB_RST_PROTOCOL    8'h05
`define VRB_RST_CAPABILITY  8'hD1
`define VRB_RST_POUT        8'h01
`define VRB_RST_TEMP_LIMIT  8'h64
`define VRB_RST_FAST_SLEW   8'h0A
`define VRB_RST_SLOW_SEL    8'h01
`define VRB_RST_CEILING     8'hB5
`define VRB_ZERO8           8'h00

`define VRB_SEL_DIV2        8'h01
`define VRB_SEL_DIV4        8'h02
`define VRB_SEL_DIV8        8'h04
`define VRB_SEL_DIV16       8'h08

`define VRB_CMD_FAST        5'h01
`define VRB_CMD_SLOW        5'h02
`define VRB_CMD_DECAY       5'h03
`define VRB_CMD_SET_REG     5'h04
`define VRB_CMD_GET_REG     5'h05

`define VRB_ACK_OK          2'h2
`define VRB_ACK_REJECT      2'h1

`define VRB_CMD_BITS        4'h5
`define VRB_BYTE_BITS       4'h8
`define VRB_RESP_BITS       4'hA

`define VRB_STP_OVERHEAT    0
`define VRB_STP_OVERCUR     1
`define VRB_STP_OVERVOLT    2
`define VRB_STS_REJECT      0
`define VRB_MR_READY_BIT    0

`define VRB_MV_STEP         11'h005
`define VRB_MV_BASE         11'h0F5
`define VRB_OV_MARGIN_MV    11'h096

`define VRB_CLK_PERIOD_NS   40
`define VRB_START_DELAY_NS  2500000

`endif

// >>> hw/vrb_pkg.sv
// Types shared by the rail register bank
package vrb_pkg;
   typedef enum logic [2:0] {
      VRB_DISABLED,
      VRB_STARTUP,
      VRB_SOFT_START,
      VRB_NORMAL,
      VRB_OVERVOLT,
      VRB_OVERCUR
   } vrb_power_e;

   typedef enum logic [2:0] {
      VRB_LINK_IDLE,
      VRB_LINK_CMD,
      VRB_LINK_ADDR,
      VRB_LINK_DATA,
      VRB_LINK_TURN,
      VRB_LINK_RESP
   } vrb_link_e;
endpackage : vrb_pkg

// >>> hw/vrb_rail_bank.sv
// Rail controller register bank, power-state sequencer and serial link slave
`timescale 1ns/10ps
`default_nettype none
`include "vrb_defs.svh"

module vrb_rail_bank #(
   parameter int START_CYCLES = `VRB_START_DELAY_NS / `VRB_CLK_PERIOD_NS,
   parameter logic [7:0] VENDOR_CODE = 8'h5A,
   parameter logic [7:0] PART_CODE = 8'h3C,
   parameter logic [7:0] REVISION_CODE = 8'h01,
   parameter logic [7:0] DEEP_LATENCY = 8'h00,
   parameter logic [7:0] LIGHT_LATENCY = 8'h00,
   parameter logic [7:0] EN_LATENCY = 8'h00
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic link_data_i,
   output logic link_data_o,
   output logic link_data_oe_o,
   output logic attention_n_o,
   output logic attention_oe_o,
   input wire logic enable_above_i,
   input wire logic supply_ok_i,
   input wire logic soft_start_done_i,
   input wire logic overvolt_fault_i,
   input wire logic overcur_fault_i,
   input wire logic [7:0] iout_adc_i,
   input wire logic [7:0] vout_adc_i,
   input wire logic [7:0] temp_adc_i,
   input wire logic [7:0] current_limit_sense_pin_i,
   input wire logic [7:0] boot_voltage_i,
   input wire logic [7:0] status_secondary_i,
   input wire logic [7:0] temperature_zone_i,
   output logic rail_ready_out_o,
   output logic overheat_out_n_o,
   output logic comp_active_o,
   output logic comp_clamp_o,
   output logic prot_enable_o,
   output logic prot_latch_o,
   output logic [7:0] target_voltage_code_o,
   output logic [1:0] slew_mode_o,
   output logic [10:0] target_mv_o,
   output logic [10:0] overvolt_limit_mv_o,
   output logic [7:0] slow_slew_rate_o
);

   localparam int SYNC_W = 7;

   // Two-flop synchronisers for the link clock and data, enable, supply, soft-start-done and fault pins
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_s;
   assign pin_raw = {link_clk_i, link_data_i, enable_above_i, supply_ok_i,
                     soft_start_done_i, overvolt_fault_i, overcur_fault_i};
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         logic meta_reg;
         logic sync_reg;
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= pin_raw[gi];
               sync_reg <= meta_reg;
            end
         end
         assign pin_s[gi] = sync_reg;
      end
   endgenerate

   wire lclk_s = pin_s[6];
   wire ldata_s = pin_s[5];
   wire en_s = pin_s[4];
   wire supply_s = pin_s[3];
   wire ss_done_s = pin_s[2];
   wire ov_s = pin_s[1];
   wire oc_s = pin_s[0];

   logic lclk_last_reg;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) lclk_last_reg <= 1'b0;
      else lclk_last_reg <= lclk_s;
   end
   wire lclk_rise = lclk_s & ~lclk_last_reg;
   wire lclk_fall = ~lclk_s & lclk_last_reg;

   // Register storage
   logic [7:0] temp_limit_reg;
   logic [7:0] fast_slew_reg;
   logic [7:0] slow_sel_reg;
   logic [7:0] ceiling_reg;
   logic [7:0] multi_rail_reg;
   logic [7:0] target_reg;
   logic [7:0] boot_reg;
   logic [7:0] cur_limit_reg;
   logic captured_reg;
   logic [7:0] stat_pri_reg;
   logic [7:0] stat_sec_reg;
   logic [7:0] stat_snap_reg;
   logic [7:0] pout_reg;
   logic [1:0] slew_reg;

   // Link frame slave
   vrb_pkg::vrb_link_e link_reg;
   logic [3:0] bit_cnt_reg;
   logic [4:0] cmd_reg;
   logic [7:0] addr_reg;
   logic [7:0] data_reg;
   logic [9:0] resp_reg;
   logic drive_reg;
   logic out_bit_reg;

   wire is_target_cmd = (cmd_reg == `VRB_CMD_FAST) || (cmd_reg == `VRB_CMD_SLOW) ||
                        (cmd_reg == `VRB_CMD_DECAY);
   wire is_get = (cmd_reg == `VRB_CMD_GET_REG);
   wire is_set = (cmd_reg == `VRB_CMD_SET_REG);
   wire above_ceiling = is_target_cmd && (addr_reg > ceiling_reg);
   wire frame_end = lclk_rise && (link_reg == vrb_pkg::VRB_LINK_TURN);
   wire do_target = frame_end && is_target_cmd && !above_ceiling;
   wire do_write = frame_end && is_set;
   wire do_read = frame_end && is_get;
   wire read_pri = do_read && (addr_reg == `VRB_IDX_STAT_PRI);
   wire read_sec = do_read && (addr_reg == `VRB_IDX_STAT_SEC);
   wire cmd_valid = is_target_cmd || is_get || is_set;
   wire [1:0] ack_code = (!cmd_valid || above_ceiling) ? `VRB_ACK_REJECT : `VRB_ACK_OK;

   // Slow rate is the fast rate shifted by the selector
   wire [7:0] slow_rate = (slow_sel_reg == `VRB_SEL_DIV16) ? (fast_slew_reg >> 4) :
                          (slow_sel_reg == `VRB_SEL_DIV8) ? (fast_slew_reg >> 3) :
                          (slow_sel_reg == `VRB_SEL_DIV4) ? (fast_slew_reg >> 2) :
                          (fast_slew_reg >> 1);

   // Read multiplexer; unmapped indices read zero
   logic [7:0] rd_data;
   always_comb begin
      case (addr_reg)
         `VRB_IDX_VENDOR: rd_data = VENDOR_CODE;
         `VRB_IDX_PART: rd_data = PART_CODE;
         `VRB_IDX_REVISION: rd_data = REVISION_CODE;
         `VRB_IDX_PROTOCOL: rd_data = `VRB_RST_PROTOCOL;
         `VRB_IDX_CAPABILITY: rd_data = `VRB_RST_CAPABILITY;
         `VRB_IDX_STAT_PRI: rd_data = stat_pri_reg;
         `VRB_IDX_STAT_SEC: rd_data = stat_sec_reg;
         `VRB_IDX_TEMP_ZONE: rd_data = temperature_zone_i;
         `VRB_IDX_IOUT: rd_data = iout_adc_i;
         `VRB_IDX_VOUT: rd_data = vout_adc_i;
         `VRB_IDX_TEMP: rd_data = temp_adc_i;
         `VRB_IDX_POUT: rd_data = pout_reg;
         `VRB_IDX_STAT_SNAP: rd_data = stat_snap_reg;
         `VRB_IDX_CUR_LIMIT: rd_data = cur_limit_reg;
         `VRB_IDX_TEMP_LIMIT: rd_data = temp_limit_reg;
         `VRB_IDX_FAST_SLEW: rd_data = fast_slew_reg;
         `VRB_IDX_SLOW_SLEW: rd_data = slow_rate;
         `VRB_IDX_BOOT: rd_data = boot_reg;
         `VRB_IDX_SLOW_SEL: rd_data = slow_sel_reg;
         `VRB_IDX_DEEP_LAT: rd_data = DEEP_LATENCY;
         `VRB_IDX_LIGHT_LAT: rd_data = LIGHT_LATENCY;
         `VRB_IDX_EN_LAT: rd_data = EN_LATENCY;
         `VRB_IDX_CEILING: rd_data = ceiling_reg;
         `VRB_IDX_TARGET: rd_data = target_reg;
         `VRB_IDX_MULTI_RAIL: rd_data = multi_rail_reg;
         default: rd_data = `VRB_ZERO8;
      endcase
   end

   // Frame: start bit low, 5-bit command, 8-bit index or code, 8-bit data on writes,
   // one turnaround clock, then 2-bit acknowledge and 8 data bits from the device
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         link_reg <= vrb_pkg::VRB_LINK_IDLE;
         bit_cnt_reg <= 4'h0;
         cmd_reg <= 5'h00;
         addr_reg <= 8'h00;
         data_reg <= 8'h00;
      end else if (lclk_rise) begin
         case (link_reg)
            vrb_pkg::VRB_LINK_IDLE: begin
               bit_cnt_reg <= 4'h0;
               if (!ldata_s) link_reg <= vrb_pkg::VRB_LINK_CMD;
            end
            vrb_pkg::VRB_LINK_CMD: begin
               cmd_reg <= {cmd_reg[3:0], ldata_s};
               bit_cnt_reg <= (bit_cnt_reg == `VRB_CMD_BITS - 4'h1) ? 4'h0 : bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == `VRB_CMD_BITS - 4'h1) link_reg <= vrb_pkg::VRB_LINK_ADDR;
            end
            vrb_pkg::VRB_LINK_ADDR: begin
               addr_reg <= {addr_reg[6:0], ldata_s};
               bit_cnt_reg <= (bit_cnt_reg == `VRB_BYTE_BITS - 4'h1) ? 4'h0 : bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == `VRB_BYTE_BITS - 4'h1)
                  link_reg <= is_set ? vrb_pkg::VRB_LINK_DATA : vrb_pkg::VRB_LINK_TURN;
            end
            vrb_pkg::VRB_LINK_DATA: begin
               data_reg <= {data_reg[6:0], ldata_s};
               bit_cnt_reg <= (bit_cnt_reg == `VRB_BYTE_BITS - 4'h1) ? 4'h0 : bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == `VRB_BYTE_BITS - 4'h1) link_reg <= vrb_pkg::VRB_LINK_TURN;
            end
            vrb_pkg::VRB_LINK_TURN: begin
               bit_cnt_reg <= 4'h0;
               link_reg <= vrb_pkg::VRB_LINK_RESP;
            end
            vrb_pkg::VRB_LINK_RESP: begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == `VRB_RESP_BITS - 4'h1) link_reg <= vrb_pkg::VRB_LINK_IDLE;
            end
            default: link_reg <= vrb_pkg::VRB_LINK_IDLE;
         endcase
      end
   end

   // Device data changes after the falling edge so the master samples it stable on the rise
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         resp_reg <= 10'h000;
         drive_reg <= 1'b0;
         out_bit_reg <= 1'b0;
      end else if (frame_end) begin
         resp_reg <= {ack_code, is_get ? rd_data : `VRB_ZERO8};
      end else if (lclk_fall) begin
         drive_reg <= (link_reg == vrb_pkg::VRB_LINK_RESP);
         out_bit_reg <= resp_reg[9];
         if (link_reg == vrb_pkg::VRB_LINK_RESP) resp_reg <= {resp_reg[8:0], 1'b0};
      end
   end
   assign link_data_o = out_bit_reg;
   assign link_data_oe_o = drive_reg;

   // Writable registers; writes to every other index fall through untouched
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         temp_limit_reg <= `VRB_RST_TEMP_LIMIT;
         slow_sel_reg <= `VRB_RST_SLOW_SEL;
         ceiling_reg <= `VRB_RST_CEILING;
         multi_rail_reg <= `VRB_ZERO8;
      end else if (do_write) begin
         case (addr_reg)
            `VRB_IDX_TEMP_LIMIT: temp_limit_reg <= data_reg;
            `VRB_IDX_SLOW_SEL: begin
               // Only the four legal selector codes are kept
               if (data_reg == `VRB_SEL_DIV2 || data_reg == `VRB_SEL_DIV4 ||
                   data_reg == `VRB_SEL_DIV8 || data_reg == `VRB_SEL_DIV16)
                  slow_sel_reg <= data_reg;
            end
            `VRB_IDX_CEILING: ceiling_reg <= data_reg;
            `VRB_IDX_MULTI_RAIL: multi_rail_reg <= data_reg;
            default: multi_rail_reg <= multi_rail_reg;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) fast_slew_reg <= `VRB_RST_FAST_SLEW;
      else fast_slew_reg <= fast_slew_reg;
   end

   // Power-state sequencer
   vrb_pkg::vrb_power_e pwr_reg;
   logic [31:0] delay_cnt_reg;
   wire powered = en_s && supply_s;
   wire delay_done = (delay_cnt_reg >= START_CYCLES - 1);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pwr_reg <= vrb_pkg::VRB_DISABLED;
         delay_cnt_reg <= 32'h0;
      end else if (!powered) begin
         pwr_reg <= vrb_pkg::VRB_DISABLED;
         delay_cnt_reg <= 32'h0;
      end else begin
         case (pwr_reg)
            vrb_pkg::VRB_DISABLED: pwr_reg <= vrb_pkg::VRB_STARTUP;
            vrb_pkg::VRB_STARTUP: begin
               delay_cnt_reg <= delay_cnt_reg + 32'h1;
               if (delay_done) pwr_reg <= vrb_pkg::VRB_SOFT_START;
            end
            vrb_pkg::VRB_SOFT_START: if (ss_done_s) pwr_reg <= vrb_pkg::VRB_NORMAL;
            vrb_pkg::VRB_NORMAL: begin
               if (ov_s && target_reg != `VRB_ZERO8) pwr_reg <= vrb_pkg::VRB_OVERVOLT;
               else if (oc_s) pwr_reg <= vrb_pkg::VRB_OVERCUR;
            end
            // Overvoltage latches until enable or supply drops
            vrb_pkg::VRB_OVERVOLT: pwr_reg <= vrb_pkg::VRB_OVERVOLT;
            vrb_pkg::VRB_OVERCUR: if (!oc_s) pwr_reg <= vrb_pkg::VRB_NORMAL;
            default: pwr_reg <= vrb_pkg::VRB_DISABLED;
         endcase
      end
   end

   // Straps caught once, in the first start-up cycle after power is good
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         captured_reg <= 1'b0;
         cur_limit_reg <= `VRB_ZERO8;
         boot_reg <= `VRB_ZERO8;
      end else if (pwr_reg == vrb_pkg::VRB_STARTUP && !captured_reg) begin
         captured_reg <= 1'b1;
         cur_limit_reg <= current_limit_sense_pin_i;
         boot_reg <= boot_voltage_i;
      end
   end

   // Target code: boot code on entering soft start, then only link commands move it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         target_reg <= `VRB_ZERO8;
         slew_reg <= 2'h0;
      end else if (do_target) begin
         target_reg <= addr_reg;
         slew_reg <= cmd_reg[1:0];
      end else if (pwr_reg == vrb_pkg::VRB_STARTUP && delay_done && powered) begin
         target_reg <= boot_reg;
         slew_reg <= 2'(`VRB_CMD_SLOW);
      end
   end

   // Status: hardware sets win over the clear that a read makes
   wire [7:0] pri_set = {5'h00, (pwr_reg == vrb_pkg::VRB_OVERVOLT),
                         (pwr_reg == vrb_pkg::VRB_OVERCUR), ~overheat_out_n_o};
   wire [7:0] sec_set = status_secondary_i |
                        {7'h00, (frame_end && is_target_cmd && above_ceiling)};
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stat_pri_reg <= `VRB_ZERO8;
         stat_sec_reg <= `VRB_ZERO8;
         stat_snap_reg <= `VRB_ZERO8;
      end else begin
         stat_pri_reg <= (read_pri ? `VRB_ZERO8 : stat_pri_reg) | pri_set;
         stat_sec_reg <= (read_sec ? `VRB_ZERO8 : stat_sec_reg) | sec_set;
         if (read_sec) stat_snap_reg <= stat_sec_reg;
      end
   end

   // Attention pulls low while any primary status bit is pending
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) attention_oe_o <= 1'b0;
      else attention_oe_o <= (stat_pri_reg != `VRB_ZERO8);
   end
   assign attention_n_o = 1'b0;

   // Power reading keeps the upper byte of the product
   wire [15:0] pout_full = vout_adc_i * iout_adc_i;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) pout_reg <= `VRB_RST_POUT;
      else pout_reg <= pout_full[15:8];
   end

   // Millivolt view of the target; code zero means the rail is off
   wire code_zero = (target_reg == `VRB_ZERO8);
   wire [10:0] mv_full = `VRB_MV_BASE + `VRB_MV_STEP * {3'h0, target_reg};
   wire [10:0] mv_val = code_zero ? 11'h000 : mv_full;

   // Output decode from the power state
   wire st_soft = (pwr_reg == vrb_pkg::VRB_SOFT_START);
   wire st_norm = (pwr_reg == vrb_pkg::VRB_NORMAL);
   wire st_oc = (pwr_reg == vrb_pkg::VRB_OVERCUR);
   wire amp_on = st_soft || st_norm || st_oc;
   wire ready_next = st_norm && (code_zero ? multi_rail_reg[`VRB_MR_READY_BIT] : 1'b1);
   wire prot_next = amp_on && !code_zero;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rail_ready_out_o <= 1'b0;
         comp_active_o <= 1'b0;
         comp_clamp_o <= 1'b0;
         prot_enable_o <= 1'b0;
         prot_latch_o <= 1'b0;
         overheat_out_n_o <= 1'b1;
         target_voltage_code_o <= `VRB_ZERO8;
         slew_mode_o <= 2'h0;
         target_mv_o <= 11'h000;
         overvolt_limit_mv_o <= 11'h000;
         slow_slew_rate_o <= `VRB_ZERO8;
      end else begin
         rail_ready_out_o <= ready_next;
         comp_active_o <= amp_on;
         comp_clamp_o <= amp_on && code_zero;
         prot_enable_o <= prot_next;
         prot_latch_o <= prot_next && st_norm;
         overheat_out_n_o <= !(temp_adc_i != `VRB_ZERO8 && temp_adc_i >= temp_limit_reg);
         target_voltage_code_o <= target_reg;
         slew_mode_o <= slew_reg;
         target_mv_o <= mv_val;
         overvolt_limit_mv_o <= code_zero ? 11'h000 : mv_full + `VRB_OV_MARGIN_MV;
         slow_slew_rate_o <= slow_rate;
      end
   end

endmodule : vrb_rail_bank
`default_nettype wire

// >>> sim/vrb_rail_checker.sv
// Port assertions for the rail register bank
`timescale 1ns/10ps
`default_nettype none
module vrb_rail_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic overvolt_fault_i,
   input wire logic overcur_fault_i,
   input wire logic attention_n_o,
   input wire logic attention_oe_o,
   input wire logic overheat_out_n_o,
   input wire logic rail_ready_out_o,
   input wire logic comp_active_o,
   input wire logic comp_clamp_o,
   input wire logic prot_enable_o,
   input wire logic prot_latch_o,
   input wire logic [7:0] target_voltage_code_o,
   input wire logic [10:0] target_mv_o,
   input wire logic [10:0] overvolt_limit_mv_o,
   input wire logic [7:0] slow_slew_rate_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_mv_linear: assert property (
      target_voltage_code_o != 8'h00 |-> target_mv_o == 11'h0F5 + 11'h005 * target_voltage_code_o)
      else $error("target mv not linear");
   a_ov_margin: assert property (
      target_voltage_code_o != 8'h00 |-> overvolt_limit_mv_o == target_mv_o + 11'h096)
      else $error("overvoltage limit off");
   a_clamp_zero: assert property (
      comp_clamp_o |-> !prot_enable_o && target_voltage_code_o == 8'h00)
      else $error("clamp without zero code");
   a_ready_latch: assert property (
      rail_ready_out_o && !comp_clamp_o |-> prot_latch_o && prot_enable_o && comp_active_o)
      else $error("ready without latching protection");
   a_ov_drop: assert property (
      overvolt_fault_i && !comp_clamp_o |-> ##[1:6] !rail_ready_out_o)
      else $error("ready kept on overvoltage");
   a_oc_drop: assert property (
      overcur_fault_i && prot_enable_o |-> ##[1:6] (!rail_ready_out_o && comp_active_o))
      else $error("overcurrent response wrong");
   a_attn_open: assert property (
      !overheat_out_n_o |-> ##[1:3] (attention_oe_o && !attention_n_o))
      else $error("attention not pulled on overheat");
   a_slow_rate: assert property (
      slow_slew_rate_o inside {8'h00, 8'h01, 8'h02, 8'h05})
      else $error("slow rate not a divided fast rate");
endmodule : vrb_rail_checker
bind vrb_rail_bank vrb_rail_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .overvolt_fault_i(overvolt_fault_i),
   .overcur_fault_i(overcur_fault_i), .attention_n_o(attention_n_o), .attention_oe_o(attention_oe_o),
   .overheat_out_n_o(overheat_out_n_o), .rail_ready_out_o(rail_ready_out_o), .comp_active_o(comp_active_o),
   .comp_clamp_o(comp_clamp_o), .prot_enable_o(prot_enable_o), .prot_latch_o(prot_latch_o),
   .target_voltage_code_o(target_voltage_code_o), .target_mv_o(target_mv_o),
   .overvolt_limit_mv_o(overvolt_limit_mv_o), .slow_slew_rate_o(slow_slew_rate_o));
`default_nettype wire

// >>> sim/vrb_host_model.sv
// Link master model: makes the link clock, sends frames, collects responses
`timescale 1ns/10ps
`default_nettype none
module vrb_host_model (
   input wire logic clk_i,
   input wire logic dev_data_i,
   input wire logic dev_oe_i,
   output logic link_clk_o,
   output logic line_o
);
   logic m_d = 1'b1;
   logic m_oe = 1'b0;
   initial link_clk_o = 1'b0;
   // Released line rests at the pull-up level, never the last bit
   assign line_o = dev_oe_i ? dev_data_i : (m_oe ? m_d : 1'b1);
   // One link period of 8 system clocks; clock stands low between frames
   task automatic tick(input logic b, input logic drv, output logic s);
      m_d <= b;
      m_oe <= drv;
      repeat (4) @(posedge clk_i);
      link_clk_o <= 1'b1;
      s = line_o;
      repeat (4) @(posedge clk_i);
      link_clk_o <= 1'b0;
   endtask : tick
   task automatic frame(input logic [4:0] c, input logic [7:0] i, input logic [7:0] d,
                        output logic [1:0] a, output logic [7:0] r);
      logic [21:0] bits;
      logic [9:0] resp;
      logic s;
      bits = {1'b0, c, i, d};
      for (int k = 21; k >= 0; k--) begin
         if (k >= 8 || c == 5'h04) tick(bits[k], 1'b1, s);
      end
      tick(1'b1, 1'b0, s);
      for (int k = 9; k >= 0; k--) begin
         tick(1'b1, 1'b0, s);
         resp[k] = s;
      end
      repeat (8) @(posedge clk_i);
      {a, r} = resp;
   endtask : frame
endmodule : vrb_host_model
`default_nettype wire

// >>> sim/vrb_rail_bank_test.sv
// Self-checking testbench for the rail register bank
`timescale 1ns/10ps
`default_nettype none
module vrb_rail_bank_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic en = 1'b0, sup = 1'b0, ssd = 1'b0, ovf = 1'b0, ocf = 1'b0;
   logic [7:0] iout = 8'h00, vout = 8'h00, temp = 8'h00, st2 = 8'h00;
   logic lclk, line, d_o, d_oe, attn, ready, ohn, comp, clamp, prot, latch;
   logic [7:0] code, slow;
   logic [1:0] smode;
   logic [10:0] mv, ovmv;
   int checked = 0, bad_count = 0, cyc = 0;
   logic [15:0] rst_tbl [11] = '{16'h06D1, 16'h0505, 16'h2264, 16'h240A, 16'h2A01, 16'h30B5,
                                 16'h1C00, 16'h2100, 16'h1000, 16'h1100, 16'h2C00};
   vrb_rail_bank #(.START_CYCLES(20)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(lclk),
      .link_data_i(line), .link_data_o(d_o), .link_data_oe_o(d_oe), .attention_n_o(), .attention_oe_o(attn),
      .enable_above_i(en), .supply_ok_i(sup), .soft_start_done_i(ssd), .overvolt_fault_i(ovf),
      .overcur_fault_i(ocf), .iout_adc_i(iout), .vout_adc_i(vout), .temp_adc_i(temp),
      .current_limit_sense_pin_i(8'h5B), .boot_voltage_i(8'hA0), .status_secondary_i(st2),
      .temperature_zone_i(8'h00), .rail_ready_out_o(ready), .overheat_out_n_o(ohn), .comp_active_o(comp),
      .comp_clamp_o(clamp), .prot_enable_o(prot), .prot_latch_o(latch), .target_voltage_code_o(code),
      .slew_mode_o(smode), .target_mv_o(mv), .overvolt_limit_mv_o(ovmv), .slow_slew_rate_o(slow));
   vrb_host_model host (.clk_i(clk_i), .dev_data_i(d_o), .dev_oe_i(d_oe), .link_clk_o(lclk), .line_o(line));
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic xfer(input logic [4:0] c, input logic [7:0] i, input logic [7:0] d, input logic [1:0] ea,
                       output logic [7:0] r);
      logic [1:0] a;
      host.frame(c, i, d, a, r);
      chk("ack", ea, a);
   endtask : xfer
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] r;
      xfer(5'h05, i, 8'h00, 2'h2, r);
      chk($sformatf("reg %h", i), e, r);
   endtask : rd
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] r;
      xfer(5'h04, i, d, 2'h2, r);
   endtask : wr
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask : w
   task automatic t_reset();
      chk("off", 3'h0, {ready, comp, prot});
      for (int k = 0; k < 11; k++) rd(rst_tbl[k][15:8], rst_tbl[k][7:0]);
      $display("reset test done");
   endtask : t_reset
   task automatic t_start();
      en <= 1'b1;
      sup <= 1'b1;
      w(6);
      chk("startup", 3'h0, {ready, comp, prot});
      w(30);
      chk("soft", 4'h6, {ready, comp, prot, latch});
      chk("boot", 8'hA0, code);
      ssd <= 1'b1;
      w(8);
      chk("normal", 4'hF, {ready, comp, prot, latch});
      rd(8'h26, 8'hA0);
      wr(8'h21, 8'h00);
      rd(8'h21, 8'h5B);
      $display("start test done");
   endtask : t_start
   task automatic t_target();
      logic [7:0] r;
      xfer(5'h01, 8'h9C, 8'h00, 2'h2, r);
      chk("mv", 11'h401, mv);
      chk("ovmv", 11'h497, ovmv);
      chk("mode", 2'h1, smode);
      xfer(5'h02, 8'hFF, 8'h00, 2'h1, r);
      chk("kept", 8'h9C, code);
      rd(8'h11, 8'h01);
      rd(8'h1C, 8'h01);
      xfer(5'h07, 8'h9C, 8'h00, 2'h1, r);
      wr(8'h30, 8'hFF);
      xfer(5'h02, 8'hFF, 8'h00, 2'h2, r);
      chk("mv max", 11'h5F0, mv);
      chk("mode", 2'h2, smode);
      xfer(5'h03, 8'h00, 8'h00, 2'h2, r);
      chk("zero", 5'h07, {ready, prot, clamp, smode});
      wr(8'h34, 8'h01);
      chk("zero rdy", 1'b1, ready);
      xfer(5'h01, 8'h9C, 8'h00, 2'h2, r);
      chk("back", 1'b1, ready);
      $display("target test done");
   endtask : t_target
   task automatic t_slow();
      for (int k = 0; k < 4; k++) begin
         wr(8'h2A, 8'h01 << k);
         rd(8'h2A, 8'h01 << k);
         chk("slow", 8'h0A >> (k + 1), slow);
      end
      wr(8'h2A, 8'h03);
      rd(8'h2A, 8'h08);
      $display("slow test done");
   endtask : t_slow
   task automatic t_sense();
      iout <= 8'hFF;
      vout <= 8'h40;
      temp <= 8'h30;
      w(2);
      rd(8'h15, 8'hFF);
      rd(8'h16, 8'h40);
      rd(8'h17, 8'h30);
      rd(8'h18, 8'h3F);
      temp <= 8'h64;
      w(8);
      chk("hot", 2'h1, {ohn, attn});
      temp <= 8'h00;
      rd(8'h10, 8'h01);
      rd(8'h10, 8'h00);
      chk("attn", 1'b0, attn);
      wr(8'h22, 8'h20);
      temp <= 8'h21;
      w(8);
      chk("hot low", 1'b0, ohn);
      temp <= 8'h00;
      rd(8'h10, 8'h01);
      st2 <= 8'h40;
      rd(8'h11, 8'h40);
      rd(8'h1C, 8'h40);
      st2 <= 8'h00;
      $display("sense test done");
   endtask : t_sense
   task automatic t_fault();
      ocf <= 1'b1;
      w(8);
      chk("oc", 2'h1, {ready, comp});
      ocf <= 1'b0;
      w(8);
      chk("oc end", 1'b1, ready);
      rd(8'h10, 8'h02);
      ovf <= 1'b1;
      w(8);
      chk("ov", 1'b0, ready);
      rd(8'h10, 8'h04);
      $display("fault test done");
   endtask : t_fault
   task automatic finish_test();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Some 46 frames of 208 to 272 clocks each fit well inside the ceiling
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      w(2);
      rst_n_i <= 1'b1;
      w(4);
      t_reset();
      t_start();
      t_target();
      t_slow();
      t_sense();
      t_fault();
      finish_test();
   end
endmodule : vrb_rail_bank_test
`default_nettype wire
